// ### common/timer_defines.svh
// Offsets, field positions and masks of the triple 8-bit timer
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CTL_C 16'hff41
`define IDX_CTL_A 16'hff4d
`define IDX_CTL_B 16'hff4e
`define IDX_CAR   16'hff4f
`define IDX_CMP_A 16'hff50
`define IDX_LO_B  16'hff51
`define IDX_HI_B  16'hff52
`define IDX_LO_C  16'hff53
`define IDX_HI_C  16'hff54
`define IDX_CNT_A 16'hff55
`define IDX_CNT_B 16'hff56
`define IDX_CNT_C 16'hff57
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define EN_BIT    7
`define EDGE_BIT  6
`define CLK_HI    5
`define CLK_LO    3
`define MODE_HI   2
`define MODE_LO   1
`define OE_BIT    0
`define RMC_BIT   2
`define NRZB_BIT  1
`define NRZ_BIT   0
`define CTL_BC_MASK 8'hbf
`define STATE_RST '0
`endif

// ### common/timer_pkg.sv
// Types of the triple 8-bit timer
package timer_pkg;
    typedef enum logic [2:0] {A_STAND, A_CASC, A_CARR, A_PWM, A_BAD}
        a_mode_type;
    typedef enum logic [2:0] {B_STAND, B_CASC, B_CARR, B_PPG, B_BAD}
        b_mode_type;
    typedef struct packed {
        logic [7:0]  ctl_a;
        logic [7:0]  ctl_b;
        logic [7:0]  ctl_c;
        logic [2:0]  car;
        logic [7:0]  cmp_a;
        logic [7:0]  lo_b;
        logic [7:0]  hi_b;
        logic [7:0]  lo_c;
        logic [7:0]  hi_c;
        logic [7:0]  cnt_a;
        logic [7:0]  cnt_b;
        logic [7:0]  cnt_c;
        logic [6:0]  pre;
        logic [2:0]  evn_b;
        logic [2:0]  evn_c;
        logic        ev_b_q;
        logic        ev_c_q;
        logic        lvl_a_q;
        logic        out_a;
        logic        out_b;
        logic        out_c;
        logic        irq_a;
        logic        irq_b;
        logic        irq_c;
        logic        pin_a;
        logic        pin_b;
        logic        pin_c;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } state_type;
endpackage : timer_pkg

// ### rtl/triple_timer.sv
// Three 8-bit timers with cascade, carrier, PWM and PPG modes
// How it works
// - B and C in carrier/PPG clear on enable off, either compare, overflow.
// - A in PWM clears only on enable off or overflow.
// - A enable 0 clears and halts the A counter; 1 counts.
// - A both-edge counting only in PWM; else rising edges.
// - A clock: main clock, /8, /128, sub clock, B match, B output.
// - A mode decoded from A and B mode bits.
// - B mode decoded from the same four bits.
// - Cascade: B enable starts, clears and stops both counters.
// - Cascade: A is clocked by B, whatever A clock select holds.
// - Output enables gate pins; A output off in cascade.
// - B clock: main clock, /4, event input, event /2, /4, /8.
// - Carrier: data 0 drives low; 1 gives carrier or steady high.
// - Carrier: next-data bit copied to output data on each A match.
// - Data bit write ignored when B output on; during A irq it takes the written next-data bit.
// - C enable 0 clears and halts the C counter; 1 counts.
// - C clock: main clock, /16, event input, event /2, /4, /8.
// - C mode 00 stand-alone, 10 PPG, else prohibited.
// - In carrier/PPG the high compare sets the output high width.
`timescale 1ns/1ps
`include "timer_defines.svh"
module triple_timer
    import timer_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    // Count sources
    input  wire logic        sub_clk,
    input  wire logic        evt_b_in,
    input  wire logic        evt_c_in,
    // Timer outputs and match events
    output      logic        timer_a_output_pin,
    output      logic        timer_b_output_pin,
    output      logic        timer_c_output_pin,
    output      logic        timer_a_match_irq,
    output      logic        timer_b_match_irq,
    output      logic        timer_c_match_irq
);

// ----------------------------------------------------------------
// Decode functions
// ----------------------------------------------------------------
function automatic a_mode_type a_dec(input logic [3:0] m);
    casez (m)
        4'b00?0: a_dec = A_STAND;
        4'b0101: a_dec = A_CASC;
        4'b0011: a_dec = A_CARR;
        4'b10?0: a_dec = A_PWM;
        default: a_dec = A_BAD;
    endcase
endfunction : a_dec

function automatic b_mode_type b_dec(input logic [3:0] m);
    casez (m)
        4'b?000: b_dec = B_STAND;
        4'b0101: b_dec = B_CASC;
        4'b0011: b_dec = B_CARR;
        4'b?010: b_dec = B_PPG;
        default: b_dec = B_BAD;
    endcase
endfunction : b_dec

function automatic logic bad_sel(input logic [2:0] sel);
    bad_sel = sel > 3'h5;
endfunction : bad_sel

// Event sources share one shape; only the main clock divider differs
function automatic logic bc_tick(input logic [2:0] sel,
                                 input logic       div,
                                 input logic       rise,
                                 input logic [2:0] n);
    case (sel)
        3'h0:    bc_tick = 1'b1;
        3'h1:    bc_tick = div;
        3'h2:    bc_tick = rise;
        3'h3:    bc_tick = rise & n[0];
        3'h4:    bc_tick = rise & (n[1:0] == 2'h3);
        3'h5:    bc_tick = rise & (n == 3'h7);
        default: bc_tick = 1'b0;
    endcase
endfunction : bc_tick

function automatic logic a_lvl(input logic [2:0] sel,
                               input logic [6:0] pre,
                               input logic       sub,
                               input logic       mb,
                               input logic       ob);
    case (sel)
        3'h1:    a_lvl = pre[2];
        3'h2:    a_lvl = pre[6];
        3'h3:    a_lvl = sub;
        3'h4:    a_lvl = mb;
        3'h5:    a_lvl = ob;
        default: a_lvl = 1'b0;
    endcase
endfunction : a_lvl

// Returns {match, output level, next count}
function automatic logic [9:0] run8(input logic [7:0] cnt,
                                    input logic       out,
                                    input logic       tick,
                                    input logic       en,
                                    input logic       ppg,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    logic [7:0] cmp;
    cmp  = (ppg && out) ? hi : lo;
    run8 = {1'b0, out, cnt};
    if (!en)
        run8 = 10'h000;
    else if (tick && cnt == cmp)
        run8 = {1'b1, ~out, 8'h00};
    else if (tick)
        run8 = {1'b0, out, cnt + 8'h01};
endfunction : run8

// ----------------------------------------------------------------
// Decoded state
// ----------------------------------------------------------------
state_type  s_r;
state_type  s_nxt;
a_mode_type a_m;
b_mode_type b_m;
b_mode_type c_m;
logic [2:0] sel_a;
logic [2:0] sel_b;
logic [2:0] sel_c;
logic       bad_a;
logic       bad_b;
logic       bad_c;
logic       lvl_a;
logic       both_a;
logic       tick_a;
logic       tick_b;
logic       tick_c;
logic       rise_b;
logic       rise_c;
logic       acc;
logic       wr;
logic       wr_car;
logic [15:0] idx;
logic       hit_a;
logic       hit_b;
logic       hit_c;
logic [9:0] ra;
logic [9:0] rb;
logic [9:0] rc;
logic       map_ok;
logic [7:0] rd;

assign a_m = a_dec({s_r.ctl_a[`MODE_HI:`MODE_LO],
                    s_r.ctl_b[`MODE_HI:`MODE_LO]});
assign b_m = b_dec({s_r.ctl_a[`MODE_HI:`MODE_LO],
                    s_r.ctl_b[`MODE_HI:`MODE_LO]});
assign c_m = (s_r.ctl_c[`MODE_HI:`MODE_LO] == 2'h0) ? B_STAND :
             (s_r.ctl_c[`MODE_HI:`MODE_LO] == 2'h2) ? B_PPG :
             B_BAD;
assign sel_a = s_r.ctl_a[`CLK_HI:`CLK_LO];
assign sel_b = s_r.ctl_b[`CLK_HI:`CLK_LO];
assign sel_c = s_r.ctl_c[`CLK_HI:`CLK_LO];
assign bad_a = bad_sel(sel_a) || a_m == A_BAD;
assign bad_b = bad_sel(sel_b) || b_m == B_BAD;
assign bad_c = bad_sel(sel_c) || c_m == B_BAD;
assign rise_b = evt_b_in & ~s_r.ev_b_q;
assign rise_c = evt_c_in & ~s_r.ev_c_q;

// ----------------------------------------------------------------
// Count clocks
// ----------------------------------------------------------------
// Carrier clock and B output are the same wave here
assign lvl_a = a_lvl(sel_a, s_r.pre, sub_clk, s_r.irq_b,
                     s_r.out_b);
assign both_a = s_r.ctl_a[`EDGE_BIT] && a_m == A_PWM;
assign tick_a = (sel_a == 3'h0) ? 1'b1 :
                (lvl_a & ~s_r.lvl_a_q) |
                (both_a & ~lvl_a & s_r.lvl_a_q);
assign tick_b = bc_tick(sel_b, s_r.pre[1:0] == 2'h3, rise_b,
                        s_r.evn_b);
assign tick_c = bc_tick(sel_c, s_r.pre[3:0] == 4'hf, rise_c,
                        s_r.evn_c);

// ----------------------------------------------------------------
// Register bus decode
// ----------------------------------------------------------------
assign idx    = paddr[17:2];
assign acc    = psel & penable;
assign wr     = acc & s_r.pready & pwrite & map_ok;
assign wr_car = wr && idx == `IDX_CAR;

always_comb begin
    map_ok = 1'b1;
    rd     = 8'h00;
    case (idx)
        `IDX_CTL_A: rd = s_r.ctl_a;
        `IDX_CTL_B: rd = s_r.ctl_b;
        `IDX_CTL_C: rd = s_r.ctl_c;
        `IDX_CAR:   rd = {5'h00, s_r.car[2:1], 1'b0};
        `IDX_CMP_A: rd = s_r.cmp_a;
        `IDX_LO_B:  rd = s_r.lo_b;
        `IDX_HI_B:  rd = s_r.hi_b;
        `IDX_LO_C:  rd = s_r.lo_c;
        `IDX_HI_C:  rd = s_r.hi_c;
        `IDX_CNT_A: rd = s_r.cnt_a;
        `IDX_CNT_B: rd = s_r.cnt_b;
        `IDX_CNT_C: rd = s_r.cnt_c;
        default:    map_ok = 1'b0;
    endcase
end

// ----------------------------------------------------------------
// Counters
// ----------------------------------------------------------------
assign ra = run8(s_r.cnt_a, s_r.out_a, tick_a, s_r.ctl_a[`EN_BIT],
                 1'b0, s_r.cmp_a, s_r.cmp_a);
assign rb = run8(s_r.cnt_b, s_r.out_b, tick_b, s_r.ctl_b[`EN_BIT],
                 b_m == B_CARR || b_m == B_PPG,
                 s_r.lo_b, s_r.hi_b);
assign rc = run8(s_r.cnt_c, s_r.out_c, tick_c, s_r.ctl_c[`EN_BIT],
                 c_m == B_PPG, s_r.lo_c, s_r.hi_c);

always_comb begin
    s_nxt         = s_r;
    hit_a         = 1'b0;
    hit_b         = 1'b0;
    hit_c         = 1'b0;
    s_nxt.pre     = s_r.pre + 7'h01;
    s_nxt.ev_b_q  = evt_b_in;
    s_nxt.ev_c_q  = evt_c_in;
    s_nxt.lvl_a_q = lvl_a;
    if (rise_b)
        s_nxt.evn_b = s_r.evn_b + 3'h1;
    if (rise_c)
        s_nxt.evn_c = s_r.evn_c + 3'h1;
    // Cascade: one 16-bit count on the B clock, A takes the carry
    if (a_m == A_CASC) begin
        s_nxt.out_a = 1'b0;
        if (bad_sel(sel_b)) begin
        end else if (!s_r.ctl_b[`EN_BIT]) begin
            s_nxt.cnt_a = 8'h00;
            s_nxt.cnt_b = 8'h00;
            s_nxt.out_b = 1'b0;
        end else if (tick_b) begin
            if ({s_r.cnt_a, s_r.cnt_b} == {s_r.cmp_a, s_r.lo_b}) begin
                hit_b       = 1'b1;
                s_nxt.out_b = ~s_r.out_b;
                s_nxt.cnt_a = 8'h00;
                s_nxt.cnt_b = 8'h00;
            end else begin
                {s_nxt.cnt_a, s_nxt.cnt_b} =
                    {s_r.cnt_a, s_r.cnt_b} + 16'h0001;
            end
        end
    end else begin
        if (!bad_b)
            {hit_b, s_nxt.out_b, s_nxt.cnt_b} = rb;
        if (bad_a) begin
        end else if (a_m == A_PWM) begin
            // Match only marks the edge; overflow alone restarts
            if (!s_r.ctl_a[`EN_BIT]) begin
                s_nxt.cnt_a = 8'h00;
            end else if (tick_a) begin
                hit_a       = s_r.cnt_a == s_r.cmp_a;
                s_nxt.cnt_a = s_r.cnt_a + 8'h01;
            end
            s_nxt.out_a = s_r.ctl_a[`EN_BIT] &&
                          s_nxt.cnt_a < s_r.cmp_a;
        end else begin
            {hit_a, s_nxt.out_a, s_nxt.cnt_a} = ra;
        end
    end
    if (!bad_c)
        {hit_c, s_nxt.out_c, s_nxt.cnt_c} = rc;
    // Match events stay high until the next count clock
    s_nxt.irq_a = hit_a | (s_r.irq_a & ~tick_a);
    s_nxt.irq_b = hit_b | (s_r.irq_b & ~tick_b);
    s_nxt.irq_c = hit_c | (s_r.irq_c & ~tick_c);

    // ------------------------------------------------------------
    // Carrier data bits
    // ------------------------------------------------------------
    if (wr_car) begin
        s_nxt.car[2:1] = pwdata[2:1];
        if (!s_r.ctl_b[`OE_BIT])
            s_nxt.car[0] = pwdata[0];
        else if (s_r.irq_a)
            s_nxt.car[0] = pwdata[1];
    end
    // Hardware reload wins over a software write
    if (a_m == A_CARR && hit_a)
        s_nxt.car[0] = s_nxt.car[1];

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    s_nxt.pin_a = s_r.ctl_a[`OE_BIT] && a_m != A_CASC &&
                  s_r.out_a;
    if (b_m == B_CARR)
        s_nxt.pin_b = s_r.ctl_b[`OE_BIT] && s_r.car[0] &&
                      (s_r.car[2] || s_r.out_b);
    else
        s_nxt.pin_b = s_r.ctl_b[`OE_BIT] && s_r.out_b;
    s_nxt.pin_c = s_r.ctl_c[`OE_BIT] && s_r.out_c;

    // ------------------------------------------------------------
    // APB: answer one cycle into the access phase
    // ------------------------------------------------------------
    s_nxt.pready  = acc & ~s_r.pready;
    s_nxt.pslverr = acc & ~s_r.pready & ~map_ok;
    s_nxt.prdata  = (acc & ~s_r.pready & ~pwrite) ?
                    {24'h000000, rd} : 32'h00000000;
    if (wr) begin
        case (idx)
            `IDX_CTL_A: s_nxt.ctl_a = pwdata[7:0];
            `IDX_CTL_B: s_nxt.ctl_b = pwdata[7:0] & `CTL_BC_MASK;
            `IDX_CTL_C: s_nxt.ctl_c = pwdata[7:0] & `CTL_BC_MASK;
            `IDX_CMP_A: s_nxt.cmp_a = pwdata[7:0];
            `IDX_LO_B:  s_nxt.lo_b  = pwdata[7:0];
            `IDX_HI_B:  s_nxt.hi_b  = pwdata[7:0];
            `IDX_LO_C:  s_nxt.lo_c  = pwdata[7:0];
            `IDX_HI_C:  s_nxt.hi_c  = pwdata[7:0];
            default: ;
        endcase
    end
end

always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
        s_r <= `STATE_RST;
    else
        s_r <= s_nxt;
end

assign prdata             = s_r.prdata;
assign pready             = s_r.pready;
assign pslverr            = s_r.pslverr;
assign timer_a_output_pin = s_r.pin_a;
assign timer_b_output_pin = s_r.pin_b;
assign timer_c_output_pin = s_r.pin_c;
assign timer_a_match_irq  = s_r.irq_a;
assign timer_b_match_irq  = s_r.irq_b;
assign timer_c_match_irq  = s_r.irq_c;

// ----------------------------------------------------------------
// Assertions
// ----------------------------------------------------------------
default clocking cb @(posedge clk); endclocking
default disable iff (!arst_n);

a_ppg_b_clear: assert property (
    (b_m == B_PPG || b_m == B_CARR) && s_r.ctl_b[`EN_BIT] &&
    tick_b && !bad_b &&
    s_r.cnt_b == (s_r.out_b ? s_r.hi_b : s_r.lo_b)
    |=> s_r.cnt_b == 8'h00 && s_r.out_b != $past(s_r.out_b))
    else $error("ppg B did not clear on compare");
a_pwm_no_clear: assert property (
    a_m == A_PWM && s_r.ctl_a[`EN_BIT] && tick_a && !bad_a &&
    s_r.cnt_a == s_r.cmp_a && s_r.cnt_a != 8'hff
    |=> s_r.cnt_a == $past(s_r.cnt_a) + 8'h01)
    else $error("pwm counter cleared on match");
a_a_stop_clear: assert property (
    a_m != A_CASC && !bad_a && !s_r.ctl_a[`EN_BIT]
    |=> s_r.cnt_a == 8'h00)
    else $error("A counter not cleared when stopped");
a_casc_stop: assert property (
    a_m == A_CASC && !bad_sel(sel_b) && !s_r.ctl_b[`EN_BIT]
    |=> s_r.cnt_a == 8'h00 && s_r.cnt_b == 8'h00)
    else $error("cascade stop did not clear both");
a_casc_pin_off: assert property (
    a_m == A_CASC |=> !timer_a_output_pin)
    else $error("A pin driven in cascade");
a_carr_low: assert property (
    b_m == B_CARR && !s_r.car[`NRZ_BIT] |=> !timer_b_output_pin)
    else $error("carrier pin high with data 0");
a_carr_level: assert property (
    b_m == B_CARR && s_r.ctl_b[`OE_BIT] && s_r.car[`NRZ_BIT] &&
    s_r.car[`RMC_BIT] |=> timer_b_output_pin)
    else $error("remote level not held high");
a_nrz_reload: assert property (
    a_m == A_CARR && hit_a && !wr_car
    |=> s_r.car[`NRZ_BIT] == $past(s_r.car[`NRZB_BIT]))
    else $error("next data not reloaded on A match");
a_nrz_locked: assert property (
    wr_car && s_r.ctl_b[`OE_BIT] && !s_r.irq_a && !hit_a
    |=> $stable(s_r.car[`NRZ_BIT]))
    else $error("data bit written while output on");
a_c_stop_clear: assert property (
    !bad_c && !s_r.ctl_c[`EN_BIT] |=> s_r.cnt_c == 8'h00)
    else $error("C counter not cleared when stopped");
a_bad_freeze: assert property (
    a_m == A_BAD |-> !hit_a ##1 $stable(s_r.cnt_a))
    else $error("A moved under prohibited mode");

c_casc_hit: cover property (a_m == A_CASC && hit_b);
c_carr_hit: cover property (a_m == A_CARR && hit_a);
c_pwm_hit:  cover property (a_m == A_PWM && hit_a && both_a);
c_ppg_c:    cover property (c_m == B_PPG && hit_c);

endmodule : triple_timer

// ### verification/event_pins.sv
// Model of the external event pins and the subsystem clock pin
`timescale 1ns/1ps
module event_pins (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Burst request from the bench
    input  wire logic       go,
    input  wire logic [7:0] n_edges,
    output      logic       busy,
    // Pins
    output      logic       sub_clk,
    output      logic       evt_b_in,
    output      logic       evt_c_in
);
    logic [7:0] left_r;
    logic [1:0] ph_r;
    logic [2:0] sub_r;
    logic       evt_r;

    // Event lines rest low between bursts; the subsystem clock runs free
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            left_r <= 8'h00;
            ph_r   <= 2'h0;
            sub_r  <= 3'h0;
            evt_r  <= 1'b0;
        end else begin
            sub_r <= sub_r + 3'h1;
            if (go) begin
                left_r <= n_edges;
            end else if (left_r != 8'h00) begin
                ph_r <= ph_r + 2'h1;
                if (ph_r == 2'h3) begin
                    evt_r <= !evt_r;
                    if (evt_r) begin
                        left_r <= left_r - 8'h01;
                    end
                end
            end
        end
    end

    assign busy     = (left_r != 8'h00);
    assign sub_clk  = sub_r[2];
    assign evt_b_in = evt_r;
    assign evt_c_in = evt_r;
endmodule : event_pins

// ### verification/tb.sv
// Self-checking testbench of the triple 8-bit timer
`timescale 1ns/1ps
`include "timer_defines.svh"
module tb;
    import timer_pkg::*;
    logic        clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sub_clk;
    logic        evt_b_in;
    logic        evt_c_in;
    logic [2:0]  pin;
    logic [2:0]  irq;
    logic        go;
    logic [7:0]  n_edges;
    logic        busy;
    logic [7:0]  rd;
    logic [7:0]  val;
    logic [16:0] note;
    logic [16:0] notes[$];
    int          bad_count;
    int          n_compared;
    int          seed;

    triple_timer i_triple_timer (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sub_clk(sub_clk),
        .evt_b_in(evt_b_in), .evt_c_in(evt_c_in),
        .timer_a_output_pin(pin[0]), .timer_b_output_pin(pin[1]),
        .timer_c_output_pin(pin[2]), .timer_a_match_irq(irq[0]),
        .timer_b_match_irq(irq[1]), .timer_c_match_irq(irq[2]));

    event_pins i_event_pins (
        .clk(clk), .arst_n(arst_n), .go(go), .n_edges(n_edges),
        .busy(busy), .sub_clk(sub_clk), .evt_b_in(evt_b_in),
        .evt_c_in(evt_c_in));

    // ------------------------------------------------------------
    // Compare, bus and verdict tasks
    // ------------------------------------------------------------
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // Every access leaves a note {error, data mask, expected data}
    task automatic apb(input logic w, input logic [15:0] idx,
                       input logic [7:0] d, input logic [7:0] m,
                       input logic err);
        int k;
        k = 0;
        notes.push_back({err, (w ? 8'h00 : m), d & (w ? 8'h00 : m)});
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata[7:0];
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 8'h00, 1'b0);
    endtask : wr

    task automatic rdchk(input logic [15:0] idx, input logic [7:0] e);
        apb(1'b0, idx, e, 8'hff, 1'b0);
    endtask : rdchk

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            check_val(prdata[7:0] & note[15:8], note[7:0]);
            check_val({7'h00, pslverr}, {7'h00, note[16]});
            check_val({7'h00, |prdata[31:8]}, 8'h00);
        end
    end

    task automatic pin_hold(input int b, input logic v, input int n);
        repeat (n) begin
            @(negedge clk);
            check_val({7'h00, pin[b]}, {7'h00, v});
        end
    endtask : pin_hold

    // Counts high samples of a pin over n cycles of steady running
    task automatic pin_duty(input int b, input int n, input int e);
        int hi;
        hi = 0;
        repeat (n) begin
            @(negedge clk);
            if (pin[b] === 1'b1) hi++;
        end
        check_val(hi[7:0], e[7:0]);
    endtask : pin_duty

    // Counts match pulses of one timer over k periods after the first one
    task automatic irq_rate(input int b, input int k, input int per);
        int   n;
        int   t;
        logic p;
        n = 0;
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (irq[b] !== 1'b1 && t < 500);
        p = 1'b1;
        repeat (per * k) begin
            @(negedge clk);
            if (irq[b] === 1'b1 && !p) n++;
            p = irq[b];
        end
        check_val(n[7:0], k[7:0]);
    endtask : irq_rate

    task automatic burst(input logic [7:0] n);
        int t;
        t = 0;
        @(posedge clk);
        go      <= 1'b1;
        n_edges <= n;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            t++;
        end while (busy && t < 200);
        repeat (4) @(posedge clk);
    endtask : burst

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict;
    end

    initial begin
        seed = 32'h3180;
        bad_count = 0;
        n_compared = 0;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h00000;
        pwdata = 32'h00000000;
        go = 1'b0;
        n_edges = 8'h00;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rdchk(`IDX_CTL_C, 8'h00);
        rdchk(`IDX_CTL_A, 8'h00);
        rdchk(`IDX_CTL_B, 8'h00);
        rdchk(`IDX_CAR, 8'h00);
        apb(1'b0, 16'hff40, 8'h00, 8'hff, 1'b1);
        for (int i = 0; i < 5; i++) begin
            val = 8'($random(seed));
            wr(`IDX_CMP_A + 16'(i), val);
            rdchk(`IDX_CMP_A + 16'(i), val);
        end
        wr(`IDX_CTL_B, 8'h5e);
        rdchk(`IDX_CTL_B, 8'h1e);
        wr(`IDX_CTL_C, 8'h5e);
        rdchk(`IDX_CTL_C, 8'h1e);
        wr(`IDX_CTL_C, 8'h00);
        wr(`IDX_CTL_B, 8'h00);
        wr(`IDX_CMP_A, 8'h02);
        wr(`IDX_CTL_A, 8'h80);
        irq_rate(0, 10, 3);
        pin_hold(0, 1'b0, 4);
        wr(`IDX_CTL_A, 8'h00);
        rdchk(`IDX_CNT_A, 8'h00);
        wr(`IDX_LO_B, 8'hff);
        wr(`IDX_LO_C, 8'hff);
        wr(`IDX_CTL_B, 8'h90);
        wr(`IDX_CTL_C, 8'h90);
        burst(8'h06);
        rdchk(`IDX_CNT_B, 8'h06);
        rdchk(`IDX_CNT_C, 8'h06);
        wr(`IDX_CTL_C, 8'h00);
        rdchk(`IDX_CNT_C, 8'h00);
        wr(`IDX_CTL_B, 8'h00);
        wr(`IDX_CTL_B, 8'h30);
        wr(`IDX_CTL_B, 8'hb0);
        burst(8'h06);
        rdchk(`IDX_CNT_B, 8'h00);
        wr(`IDX_CTL_B, 8'h00);
        wr(`IDX_LO_B, 8'h01);
        wr(`IDX_HI_B, 8'h01);
        wr(`IDX_CTL_B, 8'h06);
        wr(`IDX_CAR, 8'h07);
        wr(`IDX_CTL_B, 8'h87);
        // The pin shows the new control one cycle after the write
        @(posedge clk);
        pin_hold(1, 1'b1, 8);
        wr(`IDX_CAR, 8'h00);
        irq_rate(1, 10, 2);
        pin_duty(1, 20, 10);
        rdchk(`IDX_CAR, 8'h00);
        wr(`IDX_CMP_A, 8'h00);
        wr(`IDX_CTL_A, 8'ha8);
        repeat (100) @(posedge clk);
        pin_hold(1, 1'b0, 8);
        wr(`IDX_CTL_A, 8'h00);
        wr(`IDX_CTL_B, 8'h00);
        wr(`IDX_CMP_A, 8'hff);
        wr(`IDX_LO_B, 8'hff);
        wr(`IDX_CTL_A, 8'h02);
        wr(`IDX_CTL_B, 8'h82);
        repeat (700) @(posedge clk);
        apb(1'b0, `IDX_CNT_A, 8'h00, 8'h00, 1'b0);
        check_val({7'h00, rd != 8'h00}, 8'h01);
        wr(`IDX_CTL_B, 8'h02);
        rdchk(`IDX_CNT_A, 8'h00);
        rdchk(`IDX_CNT_B, 8'h00);
        wr(`IDX_CTL_B, 8'h00);
        wr(`IDX_CMP_A, 8'h40);
        wr(`IDX_LO_C, 8'h01);
        wr(`IDX_HI_C, 8'h03);
        wr(`IDX_CTL_A, 8'h05);
        wr(`IDX_CTL_C, 8'h05);
        wr(`IDX_CTL_A, 8'h85);
        wr(`IDX_CTL_C, 8'h85);
        irq_rate(0, 2, 256);
        pin_duty(0, 256, 64);
        irq_rate(2, 10, 3);
        pin_duty(2, 18, 12);
        give_verdict;
    end
endmodule : tb
